// [src/shc_pkg.sv]
/*
  Constants and types for the system clock and halt control block.
  Assumes a 125 MHz register clock and an APB slave with 32-bit data.
*/
package shc_pkg;

  // Register clock rate, used to reason about oscillator sampling.
  localparam int SHC_REF_CLK_HZ = 125000000;

  // Nominal oscillator frequencies in hertz, as printed.
  localparam int SHC_RC_OSC_HZ = 879236;
  localparam int SHC_QUARTZ_OSC_HZ = 32768;

  // Register indices as printed; each register takes one aligned word.
  localparam logic [11:0] SHC_PCTL_IDX = 12'h107;
  localparam logic [11:0] SHC_OSC_IDX = 12'h10E;
  localparam logic [11:0] SHC_PCTL_ADDR = {SHC_PCTL_IDX[9:0], 2'b00};
  localparam logic [11:0] SHC_OSC_ADDR = {SHC_OSC_IDX[9:0], 2'b00};

  // Field positions in the oscillator control register.
  localparam int SHC_OSC_DIV_BIT = 7;
  localparam int SHC_OSC_SRC_HI_BIT = 5;
  localparam int SHC_OSC_SRC_LO_BIT = 4;
  localparam int SHC_OSC_RCSTOP_BIT = 1;

  // Field position in the power and halt control register.
  localparam int SHC_PCTL_HALT_BIT = 0;

  // Clock source codes and reset values.
  localparam logic [1:0] SHC_SRC_RC = 2'h0;
  localparam logic [1:0] SHC_SRC_QUARTZ = 2'h2;
  localparam logic SHC_DIV_RESET = 1'h0;
  localparam logic SHC_RCSTOP_RESET = 1'h0;

  // Last count of each cycle clock period (period minus one), and their high phases, in source edges.
  localparam logic [3:0] SHC_DIV6_LAST = 4'h5;
  localparam logic [3:0] SHC_DIV12_LAST = 4'hB;
  localparam logic [3:0] SHC_DIV6_HIGH = 4'h3;
  localparam logic [3:0] SHC_DIV12_HIGH = 4'h6;

  // Interrupt level in service (none, low, high, highest).
  localparam logic [1:0] SHC_LVL_NONE = 2'h0;
  localparam logic [1:0] SHC_LVL_LOW = 2'h1;
  localparam logic [1:0] SHC_LVL_HIGH = 2'h2;
  localparam logic [1:0] SHC_LVL_HIGHEST = 2'h3;

  // Operating mode of the core.
  typedef enum logic {
    SHC_MODE_RUN,
    SHC_MODE_HALT
  } shc_mode_type;

endpackage : shc_pkg

// [src/shc_top.sv]
/*
  System clock selection, cycle clock division and halt control, with
  an APB register slave. Assumes oscillator outputs arrive as pins, and
  that the interrupt controller presents enabled pending requests sorted
  by priority level together with the level currently in service.
*/
// The APB slave port was decided locally.
// Notes on behaviour
// - Two sources, fast RC and slow quartz, either selectable as system clock.
// - Source field 00 picks RC, 10 picks quartz; 01 and 11 prohibited.
// - Hardware reset forces the source selection back to RC.
// - Divide bit one gives source/6, zero gives source/12.
// - RC stop bit is inverted: one stops the RC oscillator, zero runs.
// - Always-on clock runs in halt; execution clock stops in halt.
// - Writing one to halt bit enters halt and stops execution clock.
// - Interrupt wake clears the halt bit without software help.
// - Writing zero to the halt bit changes nothing.
// - Peripherals keep running in halt; CPU stops; ports and RAM hold.
// - Reset low ends halt; release starts a normal cold start.
// - Low and high wake need master enable plus the source's own request enable.
// - Requests at or below the level in service neither wake nor enter.
// - None: low/high/highest wake; low: high+; high: highest; highest: none.
// - Highest-level external requests wake regardless of master enable.
`timescale 1ns/10ps
module shc_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_osc_in,
  input wire logic quartz_osc_in,
  input wire logic master_irq_enable,
  input wire logic irq_low_req,
  input wire logic irq_high_req,
  input wire logic irq_highest_req,
  input wire logic [1:0] irq_level_active,
  output logic rc_osc_stop,
  output logic quartz_selected,
  output logic always_on_clock,
  output logic execution_clock,
  output logic halt_active,
  output logic halt_wake
);
  import shc_pkg::*;

  // Complete state of the block.
  typedef struct packed {
    logic rc_meta;
    logic rc_sync;
    logic rc_prev;
    logic qz_meta;
    logic qz_sync;
    logic qz_prev;
    logic cycle_divide_select;
    logic clock_source_sel_hi;
    logic clock_source_sel_lo;
    logic rc_stop;
    shc_mode_type mode;
    logic act_quartz;
    logic act_div6;
    logic act_gate;
    logic [3:0] cnt;
    logic aon_clk;
    logic exe_clk;
    logic [7:0] rdata;
    logic slverr;
    logic wake;
  } shc_state_type;

  logic rst_meta_ff;
  logic rst_sync_ff;
  shc_state_type st_ff;
  shc_state_type nxt_st;
  logic setup_phase;
  logic wr_access;
  logic hit_pctl;
  logic hit_osc;
  logic src_edge;
  logic [3:0] last_cnt;
  logic [3:0] high_cnt;
  logic wake_ok;

  // Reset release passes two flip-flops; assertion stays asynchronous.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Bus phase decode; the slave never inserts wait states.
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign hit_pctl = (paddr == SHC_PCTL_ADDR);
  assign hit_osc = (paddr == SHC_OSC_ADDR);

  // Rising edge of the source in use, taken from the second sync stage.
  assign src_edge = st_ff.act_quartz ?
                    (st_ff.qz_sync && !st_ff.qz_prev) :
                    (st_ff.rc_sync && !st_ff.rc_prev);

  // Period and high phase of the cycle clock for the ratio in use.
  assign last_cnt = st_ff.act_div6 ? SHC_DIV6_LAST : SHC_DIV12_LAST;
  assign high_cnt = st_ff.act_div6 ? SHC_DIV6_HIGH : SHC_DIV12_HIGH;

  // Halt wake eligibility from the level in service and request level.
  always_comb begin
    wake_ok = 1'b0;
    if (irq_highest_req && irq_level_active != SHC_LVL_HIGHEST) begin
      wake_ok = 1'b1;
    end
    if (master_irq_enable && irq_high_req &&
        (irq_level_active == SHC_LVL_NONE ||
         irq_level_active == SHC_LVL_LOW)) begin
      wake_ok = 1'b1;
    end
    if (master_irq_enable && irq_low_req &&
        irq_level_active == SHC_LVL_NONE) begin
      wake_ok = 1'b1;
    end
  end

  // Next state of the whole block.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wake = 1'b0;

    // Oscillator pins pass two flip-flops before any edge detection.
    nxt_st.rc_meta = rc_osc_in;
    nxt_st.rc_sync = st_ff.rc_meta;
    nxt_st.rc_prev = st_ff.rc_sync;
    nxt_st.qz_meta = quartz_osc_in;
    nxt_st.qz_sync = st_ff.qz_meta;
    nxt_st.qz_prev = st_ff.qz_sync;

    // Register writes land at the access phase.
    if (wr_access && hit_osc) begin
      nxt_st.cycle_divide_select = pwdata[SHC_OSC_DIV_BIT];
      nxt_st.clock_source_sel_hi = pwdata[SHC_OSC_SRC_HI_BIT];
      nxt_st.clock_source_sel_lo = pwdata[SHC_OSC_SRC_LO_BIT];
      nxt_st.rc_stop = pwdata[SHC_OSC_RCSTOP_BIT];
    end

    // Halt mode: a written one enters, a written zero is ignored.
    case (st_ff.mode)
      SHC_MODE_RUN: begin
        if (wr_access && hit_pctl && pwdata[SHC_PCTL_HALT_BIT]) begin
          nxt_st.mode = SHC_MODE_HALT;
        end
      end
      SHC_MODE_HALT: begin
        if (wake_ok) begin
          nxt_st.mode = SHC_MODE_RUN;
          nxt_st.wake = 1'b1;
        end
      end
      default: begin
        nxt_st.mode = SHC_MODE_RUN;
      end
    endcase

    // Cycle clock divider; settings are adopted only at a period boundary.
    if (src_edge) begin
      if (st_ff.cnt >= last_cnt) begin
        nxt_st.cnt = 4'h0;
        nxt_st.act_quartz = ({st_ff.clock_source_sel_hi,
                              st_ff.clock_source_sel_lo} ==
                             SHC_SRC_QUARTZ);
        nxt_st.act_div6 = st_ff.cycle_divide_select;
        nxt_st.act_gate = (st_ff.mode == SHC_MODE_RUN);
      end else begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
      end
    end

    // Derived clocks come from flip-flops, high in the first half period.
    nxt_st.aon_clk = (nxt_st.cnt < high_cnt);
    nxt_st.exe_clk = (nxt_st.cnt < high_cnt) && nxt_st.act_gate;

    // Read data is captured in the setup phase and held for the access.
    if (setup_phase) begin
      nxt_st.rdata = 8'h00;
      nxt_st.slverr = 1'b0;
      if (hit_osc) begin
        nxt_st.rdata[SHC_OSC_DIV_BIT] = st_ff.cycle_divide_select;
        nxt_st.rdata[SHC_OSC_SRC_HI_BIT] = st_ff.clock_source_sel_hi;
        nxt_st.rdata[SHC_OSC_SRC_LO_BIT] = st_ff.clock_source_sel_lo;
        nxt_st.rdata[SHC_OSC_RCSTOP_BIT] = st_ff.rc_stop;
      end else if (hit_pctl) begin
        nxt_st.rdata[SHC_PCTL_HALT_BIT] = (st_ff.mode == SHC_MODE_HALT);
      end else begin
        nxt_st.slverr = 1'b1;
      end
    end
  end

  // State register; reset selects RC, ratio 1/12, RC running, no halt.
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= '{
        rc_meta: 1'b0,
        rc_sync: 1'b0,
        rc_prev: 1'b0,
        qz_meta: 1'b0,
        qz_sync: 1'b0,
        qz_prev: 1'b0,
        cycle_divide_select: SHC_DIV_RESET,
        clock_source_sel_hi: SHC_SRC_RC[1],
        clock_source_sel_lo: SHC_SRC_RC[0],
        rc_stop: SHC_RCSTOP_RESET,
        mode: SHC_MODE_RUN,
        act_quartz: 1'b0,
        act_div6: SHC_DIV_RESET,
        act_gate: 1'b1,
        cnt: 4'h0,
        aon_clk: 1'b0,
        exe_clk: 1'b0,
        rdata: 8'h00,
        slverr: 1'b0,
        wake: 1'b0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Output assignments.
  assign prdata = {24'h000000, st_ff.rdata};
  assign pready = 1'b1;
  assign pslverr = st_ff.slverr && psel && penable;
  assign rc_osc_stop = st_ff.rc_stop;
  assign quartz_selected = st_ff.act_quartz;
  assign always_on_clock = st_ff.aon_clk;
  assign execution_clock = st_ff.exe_clk;
  assign halt_active = (st_ff.mode == SHC_MODE_HALT);
  assign halt_wake = st_ff.wake;

endmodule : shc_top

// [verif/shc_top_asserts.sv]
/* Port checker for shc_top, bound to every instance.
   Assumes the oscillator pins toggle steadily during the run. */
`timescale 1ns/10ps
module shc_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic master_irq_enable,
  input wire logic irq_low_req,
  input wire logic irq_high_req,
  input wire logic irq_highest_req,
  input wire logic [1:0] irq_level_active,
  input wire logic quartz_selected,
  input wire logic always_on_clock,
  input wire logic execution_clock,
  input wire logic halt_active,
  input wire logic halt_wake
);
  import shc_pkg::*;
  logic wk;
  logic [8:0] gap_ff;
  logic [8:0] hcnt_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // An enabled request above the level in service wakes the core.
  assign wk = (irq_highest_req && irq_level_active != SHC_LVL_HIGHEST)
    || (master_irq_enable && irq_high_req && irq_level_active <= SHC_LVL_LOW)
    || (master_irq_enable && irq_low_req && irq_level_active == SHC_LVL_NONE);
  // Counts cycles since the cycle clock moved, and cycles in halt.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_ff <= 9'h064;
      hcnt_ff <= 9'h000;
    end else begin
      gap_ff <= $changed(always_on_clock) ? 9'h000 : gap_ff + 9'h001;
      hcnt_ff <= halt_active ? hcnt_ff + 9'h001 : 9'h000;
    end
  end
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  halt_set_a: assert property (s_wr(SHC_PCTL_ADDR) ##0 pwdata[0]
    |=> halt_active) else $error("halt not entered");
  halt_zero_a: assert property (s_wr(SHC_PCTL_ADDR) ##0 !pwdata[0]
    && !wk |=> $stable(halt_active)) else $error("zero write acted");
  wake_go_a: assert property (halt_active && wk
    |=> !halt_active && halt_wake) else $error("wake missed");
  no_wake_a: assert property (halt_active && !wk |=> halt_active)
    else $error("wrong wake");
  wake_once_a: assert property (halt_wake |-> $past(wk) ##1 !halt_wake)
    else $error("bad wake pulse");
  exec_stop_a: assert property (hcnt_ff > 9'd150 |-> !execution_clock)
    else $error("exec clock in halt");
  aon_runs_a: assert property (gap_ff < 9'd250)
    else $error("always on clock stuck");
  no_runt_a: assert property ($changed(always_on_clock) |-> gap_ff >= 9'd8)
    else $error("runt pulse");
  quartz_sel_a: assert property (s_wr(SHC_OSC_ADDR) ##0 pwdata[5:4] ==
    SHC_SRC_QUARTZ |-> ##[1:300] quartz_selected) else $error("no quartz");
  reset_src_a: assert property ($rose(arst_n)
    |-> !quartz_selected && !halt_active) else $error("bad reset state");
endmodule : shc_chk
bind shc_top shc_chk u_shc_chk (.*);

// [verif/tb_system_clock_and_halt_control.sv]
/* Self-checking bench for shc_top over APB.
   Oscillator pins are free-running models driven here. */
`timescale 1ns/10ps
module tb_system_clock_and_halt_control;
  import shc_pkg::*;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, err, ex;
  logic rc_osc_in, quartz_osc_in, mie, lo, hi, hst, rc_osc_stop, halt_wake;
  logic quartz_selected, always_on_clock, execution_clock, halt_active;
  logic [1:0] lvl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] oc;
  int errors, samples_checked, p;
  shc_top i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_osc_in(rc_osc_in), .quartz_osc_in(quartz_osc_in),
    .master_irq_enable(mie), .irq_low_req(lo), .irq_high_req(hi),
    .irq_highest_req(hst), .irq_level_active(lvl),
    .rc_osc_stop(rc_osc_stop), .quartz_selected(quartz_selected),
    .always_on_clock(always_on_clock), .execution_clock(execution_clock),
    .halt_active(halt_active), .halt_wake(halt_wake));
  // Makes the 125 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Oscillator pins: RC period 4 cycles, quartz period 8 cycles.
  always @(posedge ref_clk) begin
    oc <= oc + 3'h1;
    rc_osc_in <= oc[1];
    quartz_osc_in <= oc[2];
  end
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; read data and error land in rd and err.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    // A slave that never answers counts as a mismatch.
    if (pready !== 1'b1) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wq(input logic e);
    for (int n = 0; n < 300 && quartz_selected !== e; n++) @(posedge ref_clk);
  endtask : wq
  // Measures one period of the always-on clock in ref_clk cycles.
  task automatic per();
    p = 0;
    for (int n = 0; n < 4; n++)
      while (always_on_clock !== n[0] && p < 400) begin
        @(posedge ref_clk);
        p += (n > 1);
      end
  endtask : per
  // Cuts a hang short.
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    {errors, samples_checked, oc, arst_n, lvl} = '0;
    {psel, penable, pwrite, mie, lo, hi, hst, paddr, pwdata} = '0;
    {rc_osc_in, quartz_osc_in} = '0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, SHC_OSC_ADDR, 32'h0);
    chk("osc", 32'h0, rd);
    for (int c = 3; c >= 0; c--) begin
      apb(1'b1, SHC_OSC_ADDR, {24'h0, 2'h2, c[1:0], 4'h0});
      wq(c == 2);
      chk("src", {31'h0, c == 2}, {31'h0, quartz_selected});
    end
    apb(1'b0, SHC_OSC_ADDR, 32'h0);
    chk("osc", 32'h80, rd);
    per();
    per();
    chk("div6", 32'd24, p);
    apb(1'b1, SHC_OSC_ADDR, 32'h2);
    chk("rcstop", 32'h1, {31'h0, rc_osc_stop});
    per();
    per();
    chk("div12", 32'd48, p);
    $display("clock test done");
    apb(1'b1, SHC_PCTL_ADDR, 32'h1);
    apb(1'b1, SHC_PCTL_ADDR, 32'h0);
    repeat (200) @(posedge ref_clk);
    apb(1'b0, SHC_PCTL_ADDR, 32'h0);
    chk("halt", 32'h1, rd);
    for (int l = 0; l < 4; l++)
      for (int k = 0; k < 6; k++) begin
        if (halt_active !== 1'b1) apb(1'b1, SHC_PCTL_ADDR, 32'h1);
        ex = k[2] ? l != 3 : k[0] && (k[1] ? l <= 1 : l == 0);
        {lvl, mie, lo, hi, hst} <= {l[1:0], k[0], k < 2, k[2:1] == 1, k[2]};
        repeat (3) @(posedge ref_clk);
        chk("wake", {31'h0, !ex}, {31'h0, halt_active});
        {lo, hi, hst} <= '0;
        @(posedge ref_clk);
      end
    $display("wake test done");
    apb(1'b1, SHC_OSC_ADDR, 32'hA2);
    wq(1'b1);
    if (halt_active !== 1'b1) apb(1'b1, SHC_PCTL_ADDR, 32'h1);
    arst_n <= 1'b0;
    @(posedge ref_clk);
    chk("rsthalt", 32'h0, {31'h0, halt_active});
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, SHC_OSC_ADDR, 32'h0);
    chk("rstosc", 32'h0, rd);
    apb(1'b1, 12'h000, 32'h1);
    chk("unmapped", 32'h2, {30'h0, err, halt_active});
    $display("reset test done");
    report_and_stop();
  end
endmodule : tb_system_clock_and_halt_control
